// ===== design/fp_sysreg_regs.vh
// register selects, field layouts and constant words of the fp system-register block
// assumes inclusion by bare name from the design files only
`ifndef FP_SYSREG_REGS_VH
`define FP_SYSREG_REGS_VH

// ----------------------------------------
// transfer selects
// ----------------------------------------
`define SEL_EXC_REG       3'h0
`define SEL_EXC_INSTR     3'h1
`define SEL_PRIOR_INSTR   3'h2
`define SEL_CAP_ZERO      3'h3
`define SEL_CAP_ONE       3'h4

// ----------------------------------------
// exception register fields
// ----------------------------------------
`define EXC_EX_BIT        31
`define EXC_EN_BIT        30
`define EXC_PRIOR_V_BIT   28
`define EXC_RESET         32'h0000_0000

// ----------------------------------------
// instruction fields
// ----------------------------------------
`define COND_HI           31
`define COND_LO           28
`define COND_ALWAYS       4'he
`define FD_HI             15
`define FD_LO             12
`define FD_LOW_BIT        22
`define FN_HI             19
`define FN_LO             16
`define FN_LOW_BIT        7
`define FM_HI             3
`define FM_LO             0
`define FM_LOW_BIT        5

// ----------------------------------------
// capability words
// ----------------------------------------
`define CAP_ZERO_VALUE    32'h1111_1111
`define CAP_ONE_VALUE     32'h0000_0000

// ----------------------------------------
// pipelines
// ----------------------------------------
`define PIPE_LS           2'h0
`define PIPE_MAC          2'h1
`define PIPE_DS           2'h2
`define NUM_PIPES         3
`define PIPE_DEPTH        3'h4
`define BEAT_ZERO         4'h0
`define BEAT_ONE          4'h1
`define INSTR_ZERO        32'h0000_0000

`endif

// ===== design/instr_rewrite.v
// rewrites a captured instruction so support software can replay it
// assumes single-register field encoding: four high bits plus one low bit
`include "fp_sysreg_regs.vh"

module instr_rewrite (
    // instruction in
    input  wire [31:0] instr,
    input  wire        force_vec,
    // vector iteration registers
    input  wire        vec_dst,
    input  wire        vec_n,
    input  wire        vec_m,
    input  wire [4:0]  iter_dst,
    input  wire [4:0]  iter_n,
    input  wire [4:0]  iter_m,
    // rewritten copy
    output reg  [31:0] result
);

    always @* begin
        result = instr;
        result[`COND_HI:`COND_LO] = `COND_ALWAYS;
        if (force_vec && vec_dst) begin
            result[`FD_HI:`FD_LO] = iter_dst[4:1];
            result[`FD_LOW_BIT]   = iter_dst[0];
        end
        if (force_vec && vec_n) begin
            result[`FN_HI:`FN_LO] = iter_n[4:1];
            result[`FN_LOW_BIT]   = iter_n[0];
        end
        if (force_vec && vec_m) begin
            result[`FM_HI:`FM_LO] = iter_m[4:1];
            result[`FM_LOW_BIT]   = iter_m[0];
        end
    end

endmodule

// ===== design/fp_sysreg_bank.v
// fp coprocessor system registers, exception capture and issue interlocks
// assumes the host core shares clk and drives all inputs from that clock

`include "fp_sysreg_regs.vh"

module fp_sysreg_bank (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // mode
    input  wire        fast_mode,
    // instruction issue
    input  wire        issue_valid,
    input  wire [31:0] issue_instr,
    input  wire [1:0]  issue_pipe,
    input  wire        issue_is_load,
    input  wire        issue_is_store,
    input  wire        issue_is_multi,
    input  wire        issue_dbl,
    input  wire        issue_has_dst,
    input  wire [4:0]  issue_dst,
    input  wire [4:0]  issue_src_a,
    input  wire [4:0]  issue_src_b,
    output wire        issue_stall,
    output wire        fwd_a,
    output wire        fwd_b,
    // completion
    input  wire [2:0]  pipe_done,
    input  wire        result_valid,
    input  wire [4:0]  result_dst,
    input  wire        result_dbl,
    input  wire        result_is_int,
    // load/store beats and aborts
    input  wire        ls_beat,
    input  wire        ls_abort,
    output reg  [3:0]  ls_beat_index,
    output reg         ls_restart,
    // exception capture
    input  wire        exc_detect,
    input  wire [31:0] exc_instr,
    input  wire        exc_is_vector,
    input  wire        exc_vec_dst,
    input  wire        exc_vec_n,
    input  wire        exc_vec_m,
    input  wire [4:0]  exc_iter_dst,
    input  wire [4:0]  exc_iter_n,
    input  wire [4:0]  exc_iter_m,
    output wire        bounce_req,
    // system-register transfers
    input  wire        xfer_req,
    input  wire        xfer_write,
    input  wire        xfer_flags,
    input  wire [2:0]  xfer_sel,
    input  wire [31:0] xfer_wdata,
    input  wire        xfer_priv,
    output wire        xfer_ack,
    output wire        xfer_undef,
    output reg  [31:0] xfer_rdata,
    output wire        unit_enable
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    reg rst_meta;
    reg rst_sync_n;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function sel_is_priv_only;
        input [2:0] sel;
        begin
            sel_is_priv_only = (sel == `SEL_EXC_REG) || (sel == `SEL_EXC_INSTR) ||
                               (sel == `SEL_PRIOR_INSTR);
        end
    endfunction

    function sel_is_cap;
        input [2:0] sel;
        begin
            sel_is_cap = (sel == `SEL_CAP_ZERO) || (sel == `SEL_CAP_ONE);
        end
    endfunction

    // ----------------------------------------
    // per-pipe occupancy
    // ----------------------------------------
    wire [`NUM_PIPES-1:0] issue_onehot;
    wire [`NUM_PIPES-1:0] pipe_full;
    wire [`NUM_PIPES-1:0] pipe_busy;
    wire       issue_fire;

    assign issue_onehot = 3'h1 << issue_pipe;

    genvar p;
    generate
        for (p = 0; p < `NUM_PIPES; p = p + 1) begin : g_pipe
            reg  [2:0] inflight;
            wire       take = issue_fire && issue_onehot[p];
            // each pipe counts on its own, so one stalls without holding the others
            // a stray completion on an empty pipe is ignored rather than wrapping
            always @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    inflight <= 3'h0;
                end else if (take && !pipe_done[p]) begin
                    inflight <= inflight + 3'h1;
                end else if (!take && pipe_done[p] && inflight != 3'h0) begin
                    inflight <= inflight - 3'h1;
                end
            end
            assign pipe_full[p] = (inflight == `PIPE_DEPTH);
            assign pipe_busy[p] = (inflight != 3'h0);
        end
    endgenerate

    // ----------------------------------------
    // scoreboard and forwarding
    // ----------------------------------------
    reg  [31:0] pending;
    wire        fwd_ok;
    wire        raw_a;
    wire        raw_b;
    wire        waw;
    wire        res_hazard;

    // no forwarding to stores, from integer results or across precision
    assign fwd_ok = result_valid && !result_is_int && !issue_is_store &&
                    (result_dbl == issue_dbl);
    assign fwd_a  = fwd_ok && (result_dst == issue_src_a);
    assign fwd_b  = fwd_ok && (result_dst == issue_src_b);
    assign raw_a  = pending[issue_src_a] && !fwd_a;
    assign raw_b  = pending[issue_src_b] && !fwd_b;
    assign waw    = issue_has_dst && pending[issue_dst];
    assign res_hazard = pipe_full[issue_pipe];

    // fast mode skips the write-after-write check so work starts sooner
    assign issue_stall = issue_valid && (raw_a || raw_b || res_hazard ||
                         (!fast_mode && waw));
    assign issue_fire  = issue_valid && !issue_stall;

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pending <= 32'h0000_0000;
        end else begin
            if (result_valid) begin
                pending[result_dst] <= 1'b0;
            end
            // a new claim outranks a same-cycle writeback to that register
            if (issue_fire && issue_has_dst) begin
                pending[issue_dst] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // load/store beats and abort restart
    // ----------------------------------------
    wire multi_active = ls_beat_index != `BEAT_ZERO;

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ls_beat_index <= `BEAT_ZERO;
            ls_restart    <= 1'b0;
        end else if (ls_abort) begin
            // abort outranks a same-cycle issue or beat
            // source data untouched, so a reissue simply starts over
            ls_beat_index <= `BEAT_ZERO;
            ls_restart    <= 1'b1;
        end else begin
            if (issue_fire && issue_pipe == `PIPE_LS && (issue_is_load || issue_is_store)) begin
                ls_beat_index <= `BEAT_ZERO;
                ls_restart    <= 1'b0;
            end else if (ls_beat) begin
                ls_beat_index <= ls_beat_index + `BEAT_ONE;
            end
        end
    end

    // multiple transfers only raise a fault once the first beat has moved
    assign bounce_req = exc_detect && !fast_mode &&
                        (!issue_is_multi || multi_active);

    // ----------------------------------------
    // exception capture
    // ----------------------------------------
    reg  [31:0] exc_reg;
    reg  [31:0] excepting_instruction;
    reg  [31:0] prior_issued_instruction;
    reg  [31:0] last_issued;
    reg         last_valid;
    wire [31:0] exc_rewritten;
    wire [31:0] prior_rewritten;
    wire        capture;

    assign capture = bounce_req;

    instr_rewrite u_exc_rewrite (
        .instr     (exc_instr),
        .force_vec (exc_is_vector),
        .vec_dst   (exc_vec_dst),
        .vec_n     (exc_vec_n),
        .vec_m     (exc_vec_m),
        .iter_dst  (exc_iter_dst),
        .iter_n    (exc_iter_n),
        .iter_m    (exc_iter_m),
        .result    (exc_rewritten)
    );

    instr_rewrite u_prior_rewrite (
        .instr     (last_issued),
        .force_vec (1'b0),
        .vec_dst   (1'b0),
        .vec_n     (1'b0),
        .vec_m     (1'b0),
        .iter_dst  (5'h00),
        .iter_n    (5'h00),
        .iter_m    (5'h00),
        .result    (prior_rewritten)
    );

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            last_issued <= `INSTR_ZERO;
            last_valid  <= 1'b0;
        end else if (issue_fire) begin
            last_issued <= issue_instr;
            last_valid  <= 1'b1;
        end
    end

    // ----------------------------------------
    // transfers
    // ----------------------------------------
    wire all_idle;
    wire xfer_allowed;
    wire xfer_go;
    wire wr_go;

    // waiting for every pipe to drain keeps writes from disturbing work in flight
    assign all_idle     = ~|pipe_busy && ~|pending;
    assign xfer_allowed = xfer_flags ? 1'b1 :
                          sel_is_priv_only(xfer_sel) ? xfer_priv :
                          sel_is_cap(xfer_sel) ? (exc_reg[`EXC_EN_BIT] || xfer_priv) :
                          1'b0;
    assign xfer_go      = xfer_req && all_idle;
    assign xfer_ack     = xfer_go && xfer_allowed;
    assign xfer_undef   = xfer_go && !xfer_allowed;
    assign wr_go        = xfer_ack && xfer_write && !xfer_flags;
    assign unit_enable  = exc_reg[`EXC_EN_BIT];

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            exc_reg <= `EXC_RESET;
        end else begin
            if (wr_go && xfer_sel == `SEL_EXC_REG) begin
                exc_reg <= xfer_wdata;
            end
            // a capture in the same cycle as a clearing write still wins
            if (capture) begin
                exc_reg[`EXC_EX_BIT]      <= 1'b1;
                exc_reg[`EXC_PRIOR_V_BIT] <= last_valid;
            end
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            excepting_instruction    <= `INSTR_ZERO;
            prior_issued_instruction <= `INSTR_ZERO;
        end else if (capture) begin
            excepting_instruction    <= exc_rewritten;
            prior_issued_instruction <= prior_rewritten;
        end else if (wr_go) begin
            if (xfer_sel == `SEL_EXC_INSTR) begin
                excepting_instruction <= xfer_wdata;
            end
            if (xfer_sel == `SEL_PRIOR_INSTR) begin
                prior_issued_instruction <= xfer_wdata;
            end
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // capability writes are acknowledged but land nowhere
    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            xfer_rdata <= `INSTR_ZERO;
        end else if (xfer_ack && !xfer_write) begin
            if (xfer_flags) begin
                xfer_rdata <= exc_reg;
            end else begin
                case (xfer_sel)
                    `SEL_EXC_REG:     xfer_rdata <= exc_reg;
                    `SEL_EXC_INSTR:   xfer_rdata <= excepting_instruction;
                    `SEL_PRIOR_INSTR: xfer_rdata <= prior_issued_instruction;
                    `SEL_CAP_ZERO:    xfer_rdata <= `CAP_ZERO_VALUE;
                    `SEL_CAP_ONE:     xfer_rdata <= `CAP_ONE_VALUE;
                    default:          xfer_rdata <= `INSTR_ZERO;
                endcase
            end
        end
    end

endmodule

// ===== tb/fp_sysreg_monitor.sv
// assertion checker for the fp system-register block
// assumes binding into fp_sysreg_bank, one clock domain
module fp_sysreg_monitor (
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    // mode, exception, load/store
    input wire        fast_mode,
    input wire        bounce_req,
    input wire        ls_abort,
    input wire        ls_restart,
    // transfers
    input wire        xfer_req,
    input wire        xfer_write,
    input wire        xfer_flags,
    input wire [2:0]  xfer_sel,
    input wire [31:0] xfer_wdata,
    input wire        xfer_priv,
    input wire        xfer_ack,
    input wire        xfer_undef,
    input wire [31:0] xfer_rdata,
    input wire        unit_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    wire cap_sel = xfer_sel == 3'h3 || xfer_sel == 3'h4;
    wire ins_sel = xfer_sel == 3'h1 || xfer_sel == 3'h2;

    // ----------------------------------------
    // transfer steps
    // ----------------------------------------
    sequence s_read(logic [2:0] s);
        xfer_ack && !xfer_write && !xfer_flags && xfer_sel == s;
    endsequence
    sequence s_write(logic [2:0] s);
        xfer_ack && xfer_write && !xfer_flags && xfer_sel == s;
    endsequence
    sequence s_unpriv;
        xfer_req && !xfer_priv && !xfer_flags;
    endsequence

    a_cap_zero_read:
    assert property (s_read(3'h3) |=> xfer_rdata == 32'h1111_1111) else $error("cap0 bad");
    a_cap_one_read:
    assert property (s_read(3'h4) |=> xfer_rdata == 32'h0) else $error("cap1 bad");
    a_instr_priv_only:
    assert property (s_unpriv ##0 ins_sel |-> !xfer_ack) else $error("instr reg unpriv");
    a_cap_any_mode:
    assert property (s_unpriv ##0 (cap_sel && unit_enable) |-> !xfer_undef)
        else $error("cap refused");
    a_cap_priv_only:
    assert property (s_unpriv ##0 (cap_sel && !unit_enable) |-> !xfer_ack)
        else $error("cap taken");
    a_enable_bit_write:
    assert property (s_write(3'h0) |=> unit_enable == $past(xfer_wdata[30]))
        else $error("enable bit");
    a_fast_no_bounce:
    assert property (fast_mode |-> !bounce_req) else $error("fast bounce");
    a_abort_restart:
    assert property (ls_abort |=> ls_restart) else $error("no restart");
endmodule

bind fp_sysreg_bank fp_sysreg_monitor mon (
    .clk(clk), .rst_n(rst_n), .fast_mode(fast_mode), .bounce_req(bounce_req),
    .ls_abort(ls_abort), .ls_restart(ls_restart), .xfer_req(xfer_req),
    .xfer_write(xfer_write), .xfer_flags(xfer_flags), .xfer_sel(xfer_sel),
    .xfer_wdata(xfer_wdata), .xfer_priv(xfer_priv), .xfer_ack(xfer_ack),
    .xfer_undef(xfer_undef), .xfer_rdata(xfer_rdata), .unit_enable(unit_enable)
);

// ===== tb/fp_host_model.sv
// host core model issuing system-register transfers one at a time
// assumes the block answers by xfer_ack or xfer_undef while the request is held
module fp_host_model (
    // clock
    input  wire         clk,
    // answer
    input  wire         xfer_ack,
    input  wire         xfer_undef,
    input  wire  [31:0] xfer_rdata,
    // request
    output logic        xfer_req   = 1'h0,
    output logic        xfer_write = 1'h0,
    output logic        xfer_flags = 1'h0,
    output logic [2:0]  xfer_sel   = 3'h0,
    output logic [31:0] xfer_wdata = 32'h0,
    output logic        xfer_priv  = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;

    // w counts stalled cycles; bounded so a hang shows up as a refusal
    task automatic run(input logic [2:0] sel, input logic wr, input logic pv,
                       input logic [31:0] wd, output logic ok,
                       output logic [31:0] rd, output int w, input logic fl = 1'h0);
        w = 0;
        @(posedge clk);
        xfer_req   <= 1'h1;
        xfer_write <= wr;
        xfer_flags <= fl;
        xfer_sel   <= sel;
        xfer_wdata <= wd;
        xfer_priv  <= pv;
        @(negedge clk);
        while (xfer_ack !== 1'h1 && xfer_undef !== 1'h1 && w < 400) begin
            w++;
            @(negedge clk);
        end
        ok = xfer_ack;
        @(posedge clk);
        xfer_req   <= 1'h0;
        xfer_wdata <= ~wd;
        @(negedge clk);
        rd = xfer_rdata;
    endtask
endmodule

// ===== tb/fp_sysreg_bank_tb.sv
// self-checking bench for the fp system-register block
// assumes the host model and checker are compiled first
module fp_sysreg_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {
        logic [2:0]  sel;
        logic        wr;
        logic        pv;
        logic [31:0] wd;
        logic        ok;
        logic [31:0] rd;
    } row_t;

    logic        clk = 1'h0, rst_n = 1'h0, fast_mode = 1'h0, issue_valid = 1'h0;
    logic [31:0] issue_instr = 32'h0, exc_instr = 32'h0;
    logic [1:0]  issue_pipe = 2'h0;
    logic        issue_is_load = 1'h0, issue_is_store = 1'h0, issue_is_multi = 1'h0;
    logic        issue_dbl = 1'h0, issue_has_dst = 1'h0, result_valid = 1'h0;
    logic [4:0]  issue_dst = 5'h0, issue_src_a = 5'h0, issue_src_b = 5'h0, result_dst = 5'h0;
    logic [4:0]  exc_iter_dst = 5'h0, exc_iter_n = 5'h0, exc_iter_m = 5'h0;
    logic [2:0]  pipe_done = 3'h0;
    logic        result_dbl = 1'h0, result_is_int = 1'h0, ls_beat = 1'h0, ls_abort = 1'h0;
    logic        exc_detect = 1'h0, exc_is_vector = 1'h0;
    logic        exc_vec_dst = 1'h0, exc_vec_n = 1'h0, exc_vec_m = 1'h0;
    wire         issue_stall, fwd_a, fwd_b, ls_restart, bounce_req, xfer_ack, xfer_undef;
    wire         unit_enable, xfer_req, xfer_write, xfer_flags, xfer_priv;
    wire  [3:0]  ls_beat_index;
    wire  [2:0]  xfer_sel;
    wire  [31:0] xfer_wdata, xfer_rdata;
    int          n_fail = 0, checks_done = 0, cycles = 0, w;
    logic        ok;
    logic [31:0] rd;
    row_t        rows [14];

    fp_sysreg_bank uut (
        .clk(clk), .rst_n(rst_n), .fast_mode(fast_mode), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .issue_pipe(issue_pipe), .issue_is_load(issue_is_load),
        .issue_is_store(issue_is_store), .issue_is_multi(issue_is_multi),
        .issue_dbl(issue_dbl), .issue_has_dst(issue_has_dst), .issue_dst(issue_dst),
        .issue_src_a(issue_src_a), .issue_src_b(issue_src_b), .issue_stall(issue_stall),
        .fwd_a(fwd_a), .fwd_b(fwd_b), .pipe_done(pipe_done), .result_valid(result_valid),
        .result_dst(result_dst), .result_dbl(result_dbl), .result_is_int(result_is_int),
        .ls_beat(ls_beat), .ls_abort(ls_abort), .ls_beat_index(ls_beat_index),
        .ls_restart(ls_restart), .exc_detect(exc_detect), .exc_instr(exc_instr),
        .exc_is_vector(exc_is_vector), .exc_vec_dst(exc_vec_dst), .exc_vec_n(exc_vec_n),
        .exc_vec_m(exc_vec_m), .exc_iter_dst(exc_iter_dst), .exc_iter_n(exc_iter_n),
        .exc_iter_m(exc_iter_m), .bounce_req(bounce_req), .xfer_req(xfer_req),
        .xfer_write(xfer_write), .xfer_flags(xfer_flags), .xfer_sel(xfer_sel),
        .xfer_wdata(xfer_wdata), .xfer_priv(xfer_priv), .xfer_ack(xfer_ack),
        .xfer_undef(xfer_undef), .xfer_rdata(xfer_rdata), .unit_enable(unit_enable));

    fp_host_model host (
        .clk(clk), .xfer_ack(xfer_ack), .xfer_undef(xfer_undef), .xfer_rdata(xfer_rdata),
        .xfer_req(xfer_req), .xfer_write(xfer_write), .xfer_flags(xfer_flags),
        .xfer_sel(xfer_sel), .xfer_wdata(xfer_wdata), .xfer_priv(xfer_priv));

    always #5 clk = ~clk;

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic rdchk(input logic [2:0] sel, input logic [31:0] exp);
        host.run(sel, 1'h0, 1'h1, 32'h0, ok, rd, w);
        chk(rd, exp);
    endtask

    task automatic iss(input logic [1:0] p, input logic [31:0] ins);
        @(posedge clk);
        {issue_valid, issue_pipe, issue_instr} <= {1'h1, p, ins};
        @(posedge clk);
        issue_valid <= 1'h0;
    endtask

    task automatic exc(input logic [31:0] ins, input logic v);
        @(posedge clk);
        exc_detect <= 1'h1;
        exc_instr  <= ins;
        {exc_is_vector, exc_vec_dst, exc_vec_n, exc_vec_m} <= {4{v}};
        {exc_iter_dst, exc_iter_n, exc_iter_m} <= v ? {5'h17, 5'h06, 5'h1d} : 15'h0;
        @(posedge clk);
        exc_detect <= 1'h0;
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rows = '{'{3'h3, 1'h0, 1'h1, 32'h0, 1'h1, 32'h1111_1111},
                 '{3'h3, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0},
                 '{3'h1, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0},
                 '{3'h2, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0},
                 '{3'h3, 1'h1, 1'h1, 32'hffff_ffff, 1'h1, 32'h0},
                 '{3'h3, 1'h0, 1'h1, 32'h0, 1'h1, 32'h1111_1111},
                 '{3'h4, 1'h0, 1'h1, 32'h0, 1'h1, 32'h0},
                 '{3'h0, 1'h1, 1'h1, 32'h4000_0000, 1'h1, 32'h0},
                 '{3'h4, 1'h1, 1'h0, 32'hffff_ffff, 1'h1, 32'h0},
                 '{3'h3, 1'h0, 1'h0, 32'h0, 1'h1, 32'h1111_1111},
                 '{3'h4, 1'h0, 1'h0, 32'h0, 1'h1, 32'h0},
                 '{3'h1, 1'h0, 1'h0, 32'h0, 1'h0, 32'h0},
                 '{3'h5, 1'h0, 1'h1, 32'h0, 1'h0, 32'h0},
                 '{3'h0, 1'h0, 1'h1, 32'h0, 1'h1, 32'h4000_0000}};
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(unit_enable, 1'h0);
        foreach (rows[i]) begin
            host.run(rows[i].sel, rows[i].wr, rows[i].pv, rows[i].wd, ok, rd, w);
            chk(ok, rows[i].ok);
            if (!rows[i].wr && rows[i].ok)
                chk(rd, rows[i].rd);
        end
        // transfer must wait for the busy multiply-add pipe
        iss(2'h1, 32'h3123_4567);
        fork
            host.run(3'h4, 1'h0, 1'h1, 32'h0, ok, rd, w);
            begin
                repeat (6) @(posedge clk);
                pipe_done <= 3'h2;
                @(posedge clk);
                pipe_done <= 3'h0;
            end
        join
        chk(w, 32'h6);
        chk(ok, 1'h1);
        chk(rd, 32'h0);
        exc(32'h5abc_def0, 1'h0);
        rdchk(3'h1, 32'heabc_def0);
        rdchk(3'h2, 32'he123_4567);
        rdchk(3'h0, 32'hd000_0000);
        host.run(3'h0, 1'h0, 1'h0, 32'h0, ok, rd, w, 1'h1);
        chk(ok, 1'h1);
        chk(rd, 32'hd000_0000);
        exc(32'hffff_ffff, 1'h1);
        rdchk(3'h1, 32'heff3_bf7e);
        rdchk(3'h2, 32'he123_4567);
        @(posedge clk);
        fast_mode <= 1'h1;
        exc(32'h0, 1'h0);
        fast_mode      <= 1'h0;
        issue_is_multi <= 1'h1;
        exc(32'h0, 1'h0);
        issue_is_multi <= 1'h0;
        rdchk(3'h1, 32'heff3_bf7e);
        iss(2'h0, 32'h0);
        ls_beat <= 1'h1;
        @(posedge clk);
        ls_beat  <= 1'h0;
        ls_abort <= 1'h1;
        @(negedge clk);
        chk(ls_beat_index, 4'h1);
        @(posedge clk);
        ls_abort <= 1'h0;
        @(negedge clk);
        chk(ls_restart, 1'h1);
        chk(ls_beat_index, 4'h0);
        @(posedge clk);
        {issue_valid, issue_pipe, issue_has_dst, issue_dst} <= {1'h1, 2'h1, 1'h1, 5'h05};
        @(posedge clk);
        {issue_has_dst, issue_src_a, issue_src_b} <= {1'h0, 5'h05, 5'h09};
        @(negedge clk);
        chk(issue_stall, 1'h1);
        @(posedge clk);
        {result_valid, result_dst} <= {1'h1, 5'h05};
        @(negedge clk);
        chk({fwd_a, fwd_b, issue_stall}, 3'h4);
        @(posedge clk);
        result_is_int <= 1'h1;
        @(negedge clk);
        chk(fwd_a, 1'h0);
        @(posedge clk);
        {issue_valid, result_valid} <= 2'h0;
        tally_and_finish();
    end
endmodule
